// [verilog/nvw_pkg.sv]
package nvw_pkg;

	// clock and programming time
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned PROG_TIME_MS = 5;
	// longest time; 20 MHz is a whole number of kHz, so the integer division is exact
	localparam int unsigned PROG_CYCLES = PROG_TIME_MS * (CLK_HZ / 1000);

	// widths
	localparam int WIPER_W = 7;
	localparam int BYTE_W = 8;
	localparam int TAPS = 128;

	// first byte layout: type id, two address bits, direction
	localparam int ID_HI = 7;
	localparam int ID_LO = 3;
	localparam int AD_HI = 2;
	localparam int AD_LO = 1;
	localparam int RW_BIT = 0;
	// value is arbitrary, not tied to any product
	localparam logic [4:0] TYPE_ID = 5'h13;

	// register pointers and access selections
	localparam logic [7:0] STORE_ADDR = 8'h00;
	localparam logic [7:0] ACCESS_SEL_ADDR = 8'h02;
	localparam logic [7:0] SEL_STORE = 8'h00;
	localparam logic [7:0] SEL_LIVE = 8'h80;
	localparam logic [7:0] SEL_RESET = 8'h80;

	// wiper values
	localparam logic [6:0] WIPER_MID = 7'h40;
	localparam logic [6:0] NV_INIT = 7'h40;

	// bit counter marks
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;

	typedef enum logic [2:0] {
		LK_IDLE = 3'b000,
		LK_ADDR = 3'b001,
		LK_REG = 3'b010,
		LK_DATA = 3'b011,
		LK_RDATA = 3'b100
	} nvw_link_st_t;

	typedef enum logic [1:0] {
		PU_MID = 2'b00,
		PU_LOAD = 2'b01,
		PU_RUN = 2'b10
	} nvw_pu_st_t;

endpackage : nvw_pkg

// [verilog/nvw_link_if.sv]
`timescale 1ns/1ns
interface nvw_link_if;
	logic start_tgl;
	logic busy;
	logic [7:0] rd_byte;
	logic wr_tgl;
	logic [7:0] wr_ptr;
	logic [7:0] wr_data;

	modport link (
		input start_tgl,
		input busy,
		input rd_byte,
		output wr_tgl,
		output wr_ptr,
		output wr_data
	);

	modport core (
		output start_tgl,
		output busy,
		output rd_byte,
		input wr_tgl,
		input wr_ptr,
		input wr_data
	);
endinterface : nvw_link_if

// [verilog/nvw_nvcell.sv]
`timescale 1ns/1ns
module nvw_nvcell
	import nvw_pkg::*;
#(
	parameter int unsigned CYCLES = PROG_CYCLES,
	parameter logic [6:0] INIT = NV_INIT
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// programming request
	input wire logic prog_req,
	input wire logic [6:0] prog_data,
	// state
	output logic busy,
	output logic [6:0] data
);
	localparam int CW = $clog2(CYCLES + 1);

	// nonvolatile: survives reset, only a finished program cycle changes it
	logic [6:0] cell_q = INIT;
	logic [6:0] hold_q;
	logic [CW-1:0] cnt_q;
	logic busy_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			cnt_q <= '0;
			hold_q <= '0;
		end else if (ce) begin
			if (busy_q) begin
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == '0) busy_q <= 1'b0;
			end else if (prog_req) begin
				busy_q <= 1'b1;
				cnt_q <= CW'(CYCLES - 1);
				hold_q <= prog_data;
			end
		end
	end

	// a reset in mid-cycle abandons the program and keeps the old word
	always_ff @(posedge clk) begin
		if (!rst && ce && busy_q && cnt_q == '0) cell_q <= hold_q;
	end

	assign busy = busy_q;
	assign data = cell_q;

endmodule : nvw_nvcell

// [verilog/nvw_link.sv]
`timescale 1ns/1ns
module nvw_link
	import nvw_pkg::*;
(
	// link clock and reset
	input wire logic scl,
	input wire logic rst,
	// pins
	input wire logic sda,
	input wire logic addr_hi,
	input wire logic addr_lo,
	output logic sda_drv,
	output logic sda_oe,
	// core side
	nvw_link_if.link lk
);
	nvw_link_st_t state_q, next_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, ptr_q, tx_q, byte_in;
	logic ack_q, st_seen_q, bsy1_q, bsy_q, wr_tgl_q;
	logic [1:0] pin1_q, pin_q;
	logic [7:0] wr_ptr_q, wr_data_q;

	assign byte_in = {sh_q[6:0], sda};

	// busy set at once; release needs two link edges
	always_ff @(posedge scl or posedge lk.busy) begin
		if (lk.busy) begin
			bsy1_q <= 1'b1;
			bsy_q <= 1'b1;
		end else begin
			bsy1_q <= 1'b0;
			bsy_q <= bsy1_q;
		end
	end

	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			pin1_q <= 2'b00;
			pin_q <= 2'b00;
		end else begin
			pin1_q <= {addr_hi, addr_lo};
			pin_q <= pin1_q;
		end
	end

	// start toggle changes while scl is high, settled by the next rise
	always_ff @(posedge scl or posedge rst) begin
		if (rst) begin
			state_q <= LK_IDLE;
			next_q <= LK_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			ptr_q <= '0;
			tx_q <= '0;
			ack_q <= 1'b0;
			st_seen_q <= 1'b0;
			wr_tgl_q <= 1'b0;
			wr_ptr_q <= '0;
			wr_data_q <= '0;
		end else if (lk.start_tgl != st_seen_q) begin
			st_seen_q <= lk.start_tgl;
			ack_q <= 1'b0;
			cnt_q <= 4'h1;
			sh_q <= {7'h00, sda};
			state_q <= bsy_q ? LK_IDLE : LK_ADDR;
		end else if (bsy_q) begin
			state_q <= LK_IDLE;
			ack_q <= 1'b0;
		end else if (state_q != LK_IDLE) begin
			if (cnt_q != BIT_ACK) begin
				sh_q <= byte_in;
				cnt_q <= cnt_q + 1'b1;
			end else begin
				cnt_q <= '0;
				ack_q <= 1'b0;
				state_q <= next_q;
				if (next_q == LK_RDATA) tx_q <= lk.rd_byte;
			end
			if (cnt_q == BIT_LAST) begin
				case (state_q)
					LK_ADDR: begin
						if (byte_in[ID_HI:ID_LO] == TYPE_ID
								&& byte_in[AD_HI:AD_LO] == pin_q) begin
							ack_q <= 1'b1;
							next_q <= byte_in[RW_BIT] ? LK_RDATA : LK_REG;
						end else begin
							next_q <= LK_IDLE;
						end
					end
					LK_REG: begin
						ack_q <= 1'b1;
						ptr_q <= byte_in;
						next_q <= LK_DATA;
					end
					LK_DATA: begin
						ack_q <= 1'b1;
						wr_ptr_q <= ptr_q;
						wr_data_q <= byte_in;
						wr_tgl_q <= ~wr_tgl_q;
						next_q <= LK_IDLE;
					end
					default: begin
						next_q <= LK_IDLE;
					end
				endcase
			end
		end
	end

	// pin changes while scl is low
	always_ff @(negedge scl or posedge rst) begin
		if (rst) begin
			sda_drv <= 1'b1;
			sda_oe <= 1'b0;
		end else if (bsy_q) begin
			sda_drv <= 1'b1;
			sda_oe <= 1'b0;
		end else if (ack_q) begin
			sda_drv <= 1'b0;
			sda_oe <= 1'b1;
		end else if (state_q == LK_RDATA && cnt_q != BIT_ACK) begin
			sda_drv <= tx_q[3'h7 - cnt_q[2:0]];
			sda_oe <= ~tx_q[3'h7 - cnt_q[2:0]];
		end else begin
			sda_drv <= 1'b1;
			sda_oe <= 1'b0;
		end
	end

	assign lk.wr_tgl = wr_tgl_q;
	assign lk.wr_ptr = wr_ptr_q;
	assign lk.wr_data = wr_data_q;

endmodule : nvw_link

// [verilog/nvw_wiper_store.sv]
// Function
// - the wiper store keeps its word without power and is copied into the live wiper on power-up.
// - the store may be read under store selection whenever the bus is not held off, and reading never changes the live wiper.
// - only the seven low data bits are kept and the top bit reads back as zero.
// - after a store write the device runs an internal program cycle of up to 5 ms.
// - during that program cycle the bus pins are ignored and the data pin is released.
// - a store write also loads the live wiper so both hold the same position afterwards.
// - a store write is start, address byte for write, pointer 00h, one data byte, stop, each acked.
// - at the end of a store write the data goes to both registers and the device goes busy until the program cycle ends.
// - a store read is start, address write, pointer 00h, repeated start, address read, then data.
// - at power-up the wiper sits at mid-scale 64 until the stored value is loaded.
// - the seven-bit wiper value selects exactly one of 128 taps.
// - the first byte holds a five-bit type id, two address bits and the direction bit last.
`timescale 1ns/1ns
module nvw_wiper_store
	import nvw_pkg::*;
#(
	parameter int unsigned PROG_CYCLES_P = PROG_CYCLES,
	parameter logic [6:0] NV_INIT_P = NV_INIT
) (
	// system clock and reset
	input wire logic CLK,
	input wire logic RST,
	input wire logic CE,
	// serial bus
	input wire logic SCL,
	input wire logic SDA,
	output logic SDA_DRV,
	output logic SDA_OE,
	// address straps
	input wire logic SLAVE_ADDR_BIT_HI,
	input wire logic SLAVE_ADDR_BIT_LO,
	// wiper
	output logic [6:0] WIPER,
	output logic [TAPS-1:0] TAP_SEL,
	output logic NV_BUSY
);
	nvw_link_if lk ();

	// bus condition detectors, clocked by the data pin itself
	logic start_tgl_q;
	logic stop_tgl_q;

	// crossing into the system clock
	logic [2:0] wr_sync_q;
	logic [2:0] stop_sync_q;
	logic wr_ev;
	logic stop_ev;
	logic stop_ev_q;

	// core state
	nvw_pu_st_t pu_q;
	logic [7:0] sel_q;
	logic pend_q;
	logic [6:0] pend_data_q;
	logic [6:0] live_q;
	logic prog_req_q;
	logic busy_q;
	logic [7:0] rd_byte_q;
	logic [TAPS-1:0] tap_q;
	logic nv_busy;
	logic [6:0] nv_data;
	logic commit;
	logic is_store_wr;

	// a falling data edge while the clock is high opens a frame
	always_ff @(negedge SDA or posedge RST) begin
		if (RST) begin
			start_tgl_q <= 1'b0;
		end else if (SCL) begin
			start_tgl_q <= ~start_tgl_q;
		end
	end

	// a rising data edge while the clock is high closes a frame;
	// the link clock stops after it, so the core sees the close
	always_ff @(posedge SDA or posedge RST) begin
		if (RST) begin
			stop_tgl_q <= 1'b0;
		end else if (SCL) begin
			stop_tgl_q <= ~stop_tgl_q;
		end
	end

	// write toggle: the word beside it moves on the same link edge and is stable before the synchronised toggle changes
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wr_sync_q <= 3'h0;
		end else if (CE) begin
			wr_sync_q <= {wr_sync_q[1:0], lk.wr_tgl};
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stop_sync_q <= 3'h0;
		end else if (CE) begin
			stop_sync_q <= {stop_sync_q[1:0], stop_tgl_q};
		end
	end

	assign wr_ev = wr_sync_q[2] ^ wr_sync_q[1];
	assign stop_ev = stop_sync_q[2] ^ stop_sync_q[1];

	// stop handled one cycle late so a data byte crossing at the same
	// moment is already pending
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			stop_ev_q <= 1'b0;
		end else if (CE) begin
			stop_ev_q <= stop_ev;
		end
	end

	assign commit = stop_ev_q && pend_q && pu_q == PU_RUN;
	assign is_store_wr = sel_q == SEL_STORE;

	// power-up sequence
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pu_q <= PU_MID;
		end else if (CE) begin
			case (pu_q)
				PU_MID: pu_q <= PU_LOAD;
				PU_LOAD: pu_q <= PU_RUN;
				PU_RUN: pu_q <= PU_RUN;
				default: pu_q <= PU_MID;
			endcase
		end
	end

	// access selection persists across frames
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sel_q <= SEL_RESET;
		end else if (CE && wr_ev && lk.wr_ptr == ACCESS_SEL_ADDR) begin
			sel_q <= lk.wr_data;
		end
	end

	// data byte waits for the closing stop; a new byte beats the clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pend_q <= 1'b0;
			pend_data_q <= 7'h00;
		end else if (CE) begin
			if (wr_ev && lk.wr_ptr == STORE_ADDR) begin
				pend_q <= 1'b1;
				pend_data_q <= lk.wr_data[WIPER_W-1:0];
			end else if (stop_ev_q) begin
				pend_q <= 1'b0;
			end
		end
	end

	// live wiper: mid-scale, then the stored word, then bus writes
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			live_q <= WIPER_MID;
		end else if (CE) begin
			if (pu_q == PU_LOAD) begin
				live_q <= nv_data;
			end else if (commit) begin
				live_q <= pend_data_q;
			end
		end
	end

	// only a write under store selection starts a program cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			prog_req_q <= 1'b0;
		end else if (CE) begin
			prog_req_q <= commit && is_store_wr;
		end
	end

	// bus held off through power-up and any program cycle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_q <= 1'b1;
		end else if (CE) begin
			busy_q <= pu_q != PU_RUN || commit || prog_req_q || nv_busy;
		end
	end

	// read answer; the store is only changed while the bus is held off
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_byte_q <= 8'h00;
		end else if (CE) begin
			if (is_store_wr) begin
				rd_byte_q <= {1'b0, nv_data};
			end else begin
				rd_byte_q <= {1'b0, live_q};
			end
		end
	end

	// one-hot tap decode
	for (genvar i = 0; i < TAPS; i++) begin : g_tap
		always_ff @(posedge CLK or posedge RST) begin
			if (RST) begin
				tap_q[i] <= i == int'(WIPER_MID);
			end else if (CE) begin
				tap_q[i] <= live_q == WIPER_W'(i);
			end
		end
	end

	nvw_nvcell #(
		.CYCLES(PROG_CYCLES_P),
		.INIT(NV_INIT_P)
	) u_cell (
		.clk(CLK),
		.rst(RST),
		.ce(CE),
		.prog_req(prog_req_q),
		.prog_data(pend_data_q),
		.busy(nv_busy),
		.data(nv_data)
	);

	nvw_link u_link (
		.scl(SCL),
		.rst(RST),
		.sda(SDA),
		.addr_hi(SLAVE_ADDR_BIT_HI),
		.addr_lo(SLAVE_ADDR_BIT_LO),
		.sda_drv(SDA_DRV),
		.sda_oe(SDA_OE),
		.lk(lk.link)
	);

	assign lk.start_tgl = start_tgl_q;
	assign lk.busy = busy_q;
	assign lk.rd_byte = rd_byte_q;

	assign WIPER = live_q;
	assign TAP_SEL = tap_q;
	assign NV_BUSY = busy_q;

endmodule : nvw_wiper_store

// [tb/nvw_wiper_store_sva.sv]
`timescale 1ns/1ns
module nvw_wiper_store_sva
	import nvw_pkg::*;
#(
	parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// bus
	input wire logic SDA_DRV,
	input wire logic SDA_OE,
	// wiper
	input wire logic [6:0] WIPER,
	input wire logic [TAPS-1:0] TAP_SEL,
	input wire logic NV_BUSY
);
	localparam int PMAX = PROG_CYCLES_P + 4;
	logic [31:0] busy_cnt_q;

	// counts busy cycles so long waits need no big repetition
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_cnt_q <= 32'h0000_0000;
		end else begin
			busy_cnt_q <= NV_BUSY ? busy_cnt_q + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_power_mid;
		WIPER == WIPER_MID && NV_BUSY;
	endsequence
	sequence s_prog_hold;
		NV_BUSY [*8];
	endsequence

	a_power_mid: assert property ($fell(RST) |-> s_power_mid)
		else $error("wiper not at mid-scale after reset");
	a_power_load: assert property ($fell(RST) |-> ##[1:6] !NV_BUSY)
		else $error("power-up load too slow");
	a_prog_min: assert property ($rose(NV_BUSY) |-> s_prog_hold)
		else $error("program cycle too short");
	a_prog_bound: assert property (busy_cnt_q <= PMAX)
		else $error("program cycle too long");
	a_prog_wiper: assert property (busy_cnt_q > 32'h0000_0004 |-> $stable(WIPER))
		else $error("wiper moved during program cycle");
	a_busy_released: assert property (NV_BUSY |-> !SDA_OE)
		else $error("data pin driven while busy");
	a_ack_drive: assert property (SDA_OE |-> !SDA_DRV)
		else $error("driven data level not low");
	a_tap_follows: assert property (1 |=> TAP_SEL == (TAPS'(1) << $past(WIPER)))
		else $error("tap select not following wiper");
	a_tap_single: assert property ($onehot(TAP_SEL))
		else $error("tap select not one-hot");
endmodule : nvw_wiper_store_sva

// [tb/nvw_i2c_mst.sv]
`timescale 1ns/1ns
module nvw_i2c_mst (
	// bus pins, released data reads high through the pull-up
	output logic scl,
	output logic sda_lvl,
	input wire logic sda
);
	// clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_lvl = 1'b1;
	end

	task automatic xbit(input logic b, output logic r);
		sda_lvl = b;
		#16;
		scl = 1'b1;
		#16;
		r = sda;
		#16;
		scl = 1'b0;
		#16;
	endtask : xbit

	// also serves as repeated start after an acknowledge
	task automatic start();
		sda_lvl = 1'b1;
		#16;
		scl = 1'b1;
		#16;
		sda_lvl = 1'b0;
		#16;
		scl = 1'b0;
		#16;
	endtask : start

	task automatic stop();
		sda_lvl = 1'b0;
		#16;
		scl = 1'b1;
		#16;
		sda_lvl = 1'b1;
		#32;
	endtask : stop

	// k is the slave acknowledge on writes, the own release on reads
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
		xbit(1'b1, k);
	endtask : xbyte
endmodule : nvw_i2c_mst

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top
	import nvw_pkg::*;
;
	localparam int unsigned PROG = 40;
	localparam logic [6:0] INIT = 7'h25;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic a_hi = 1'b0;
	logic a_lo = 1'b1;
	logic scl;
	logic sda_lvl;
	wire sda;
	logic sda_drv;
	logic sda_oe;
	logic [6:0] wiper;
	logic [TAPS-1:0] tap_sel;
	logic nv_busy;
	int num_errors = 0;
	int checks_done = 0;
	int seed = 32'h9e0c_d6e5;

	assign sda = sda_lvl & ~sda_oe;
	always #25 clk = ~clk;

	nvw_wiper_store #(.PROG_CYCLES_P(PROG), .NV_INIT_P(INIT)) nvw_wiper_store_i (
		.CLK(clk), .RST(rst), .CE(ce), .SCL(scl), .SDA(sda), .SDA_DRV(sda_drv),
		.SDA_OE(sda_oe), .SLAVE_ADDR_BIT_HI(a_hi), .SLAVE_ADDR_BIT_LO(a_lo),
		.WIPER(wiper), .TAP_SEL(tap_sel), .NV_BUSY(nv_busy)
	);
	nvw_i2c_mst nvw_i2c_mst_i (.scl(scl), .sda_lvl(sda_lvl), .sda(sda));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	// the link only listens two clock rises after busy ends, hence the idle pulses
	task automatic idle();
		int n;
		logic d;
		n = 0;
		while (nv_busy !== 1'b0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
		if (n == 1000) begin
			num_errors++;
			conclude();
		end
		repeat (3) nvw_i2c_mst_i.xbit(1'b1, d);
	endtask : idle

	function automatic logic [7:0] adr(input logic rw);
		return {TYPE_ID, a_hi, a_lo, rw};
	endfunction : adr

	task automatic wr3(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		logic k0, k1, k2;
		idle();
		nvw_i2c_mst_i.start();
		nvw_i2c_mst_i.xbyte(adr(1'b0), q, k0);
		nvw_i2c_mst_i.xbyte(p, q, k1);
		nvw_i2c_mst_i.xbyte(d, q, k2);
		nvw_i2c_mst_i.stop();
		check({5'h00, k0, k1, k2}, 8'h00);
	endtask : wr3

	task automatic rd(input logic [7:0] exp);
		logic [7:0] q;
		logic k0, k1, k2, k3;
		idle();
		nvw_i2c_mst_i.start();
		nvw_i2c_mst_i.xbyte(adr(1'b0), q, k0);
		nvw_i2c_mst_i.xbyte(STORE_ADDR, q, k1);
		nvw_i2c_mst_i.start();
		nvw_i2c_mst_i.xbyte(adr(1'b1), q, k2);
		nvw_i2c_mst_i.xbyte(8'hff, q, k3);
		nvw_i2c_mst_i.stop();
		check({5'h00, k0, k1, k2}, 8'h00);
		check(q, exp);
	endtask : rd

	initial begin
		logic [7:0] d;
		logic [7:0] q;
		logic k;
		repeat (16) @(posedge clk);
		check({1'b0, wiper}, {1'b0, WIPER_MID});
		rst <= 1'b0;
		idle();
		check({1'b0, wiper}, {1'b0, INIT});
		wr3(ACCESS_SEL_ADDR, SEL_STORE);
		rd({1'b0, INIT});
		check({1'b0, wiper}, {1'b0, INIT});
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
			@(posedge clk);
			a_hi <= d[1];
			a_lo <= d[2];
			wr3(STORE_ADDR, d);
			repeat (7) @(posedge clk);
			check({1'b0, wiper}, {1'b0, d[6:0]});
			check({7'h00, tap_sel[d[6:0]]}, 8'h01);
			check({7'h00, nv_busy}, 8'h01);
			// a frame during programming must go unanswered
			nvw_i2c_mst_i.start();
			nvw_i2c_mst_i.xbyte(adr(1'b0), q, k);
			nvw_i2c_mst_i.stop();
			check({7'h00, k}, 8'h01);
			rd({1'b0, d[6:0]});
			idle();
			nvw_i2c_mst_i.start();
			nvw_i2c_mst_i.xbyte(adr(1'b0) ^ (i[0] ? 8'h02 : 8'h80), q, k);
			nvw_i2c_mst_i.stop();
			check({7'h00, k}, 8'h01);
		end
		// live selection: a pointer 00h write moves the wiper only, no program cycle
		wr3(ACCESS_SEL_ADDR, SEL_LIVE);
		wr3(STORE_ADDR, 8'h91);
		repeat (7) @(posedge clk);
		check({1'b0, wiper}, 8'h11);
		check({7'h00, nv_busy}, 8'h00);
		rd(8'h11);
		// second reset: live wiper restarts at mid-scale, store survives
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		check({1'b0, wiper}, {1'b0, WIPER_MID});
		rst <= 1'b0;
		idle();
		check({1'b0, wiper}, {1'b0, d[6:0]});
		conclude();
	end
endmodule : tb_top

bind nvw_wiper_store nvw_wiper_store_sva #(.PROG_CYCLES_P(PROG_CYCLES_P)) nvw_wiper_store_sva_i (
	.CLK, .RST, .SDA_DRV, .SDA_OE, .WIPER, .TAP_SEL, .NV_BUSY
);
